// ### hw/tmr_params.svh
// Constants for the 8-bit single-compare PWM timer
// Overview of operation
// - Count and compare values are 8-bit registers, processor readable and writable.
// - Tick comes from prescaler or external pin, with selectable edge.
// - Clock select zero stops the counter; the value holds.
// - Bottom flagged at 0x00, max flagged at 0xFF.
// - Top is 0xFF or the compare value, chosen by wave mode.
// - Each tick clears, increments or decrements the counter per mode.
// - Processor may read and write the count at any time.
// - Processor count write beats any clear or count that cycle.
// - Wave mode bits set counting sequence and waveform generation.
// - Overflow flag set at the mode-defined point; it may interrupt.
// - 8-bit comparator asserts match whenever count equals compare value.
// - Match flag is set at the tick after the match.
// - Match interrupt needs enable bit and global interrupt flag.
// - Match flag clears on service or on a written one.
// - Waveform output follows match, mode, compare output field, max, bottom.
// - Compare value double buffered in PWM modes only.
// - Buffered value moves to active register on the tick at max (0xFF) only.
// - Processor compare access hits buffer when buffered, else active register.
// - Force strobe in non-PWM modes acts on output only.
// - Count write blocks compare match on the following tick, even stopped; the CTC counter clear on that tick is not blocked.
// - Waveform output state keeps its value across mode changes.
// - Compare output field is unbuffered and acts at once.
// - Normal mode counts up, wraps 0xFF to 0x00, overflow at zero.
// - Clear-on-match mode clears counter on match; compare value is top.
// - Fast PWM counts bottom to max, then restarts at bottom.
// - Compare output field zero leaves the output alone on match.
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
`define TMR_BOTTOM     8'h00
`define TMR_MAX        8'hff
`define TMR_RST_BYTE   8'h00
`define TMR_CS_STOP    3'h0
`define TMR_CS_PRE1    3'h1
`define TMR_CS_PRE8    3'h2
`define TMR_CS_PRE64   3'h3
`define TMR_CS_PRE256  3'h4
`define TMR_CS_PRE1024 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7
`define TMR_COM_NONE   2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_CLEAR  2'h2
`define TMR_COM_SET    2'h3
`define TMR_PRE_W      10
`endif

// ### hw/tmr_pkg.sv
// Types for the 8-bit single-compare PWM timer
package tmr_pkg;
	typedef enum logic [1:0] {
		TMR_NORMAL = 2'h0,
		TMR_PHASE  = 2'h1,
		TMR_CTC    = 2'h2,
		TMR_FAST   = 2'h3
	} tmr_mode_e;
endpackage : tmr_pkg

// ### hw/tmr_tick_sel.sv
// Timer tick source selection: prescaler taps and synchronised count pin
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_tick_sel (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [2:0] clock_select_field,
	input  wire logic       external_count_pin,
	output logic            timer_tick
);
	logic [`TMR_PRE_W-1:0] pre_reg;
	logic [2:0]            sync_reg;
	logic                  ext_lvl_reg;
	logic                  pre_hit;
	logic                  ext_rise;
	logic                  ext_fall;

	// ==========================================
	// Free running prescaler
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + 1'b1;
		end
	end

	// ==========================================
	// Pin synchroniser; change counts when stages two and three agree
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync_reg    <= 3'h0;
			ext_lvl_reg <= 1'b0;
		end else begin
			sync_reg <= {sync_reg[1:0], external_count_pin};
			if (sync_reg[1] == sync_reg[2]) begin
				ext_lvl_reg <= sync_reg[2];
			end
		end
	end

	assign ext_rise = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !ext_lvl_reg;
	assign ext_fall = (sync_reg[1] == sync_reg[2]) && !sync_reg[2] && ext_lvl_reg;

	always_comb begin
		case (clock_select_field)
			`TMR_CS_PRE1:     pre_hit = 1'b1;
			`TMR_CS_PRE8:     pre_hit = (pre_reg[2:0] == 3'h7);
			`TMR_CS_PRE64:    pre_hit = (pre_reg[5:0] == 6'h3f);
			`TMR_CS_PRE256:   pre_hit = (pre_reg[7:0] == 8'hff);
			`TMR_CS_PRE1024:  pre_hit = (pre_reg == 10'h3ff);
			`TMR_CS_EXT_FALL: pre_hit = ext_fall;
			`TMR_CS_EXT_RISE: pre_hit = ext_rise;
			default:          pre_hit = 1'b0;
		endcase
	end

	assign timer_tick = pre_hit;
endmodule : tmr_tick_sel

// ### hw/tmr_wave.sv
// Waveform output state machine
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_wave (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [1:0] wave_mode_field,
	input  wire logic [1:0] compare_output_field,
	input  wire logic       match_event,
	input  wire logic       force_event,
	input  wire logic       bottom_event,
	input  wire logic       up_dir,
	output logic            waveform_output
);
	logic wave_reg;
	logic wave_next;
	logic pwm;

	assign pwm = wave_mode_field[0];

	always_comb begin
		wave_next = wave_reg;
		if (!pwm && (match_event || force_event)) begin
			case (compare_output_field)
				`TMR_COM_TOGGLE: wave_next = !wave_reg;
				`TMR_COM_CLEAR:  wave_next = 1'b0;
				`TMR_COM_SET:    wave_next = 1'b1;
				default:         wave_next = wave_reg;
			endcase
		end else if (pwm && compare_output_field[1]) begin
			if (match_event) begin
				// Non-inverting clears on up match, sets on down match
				wave_next = compare_output_field[0] ^ !up_dir;
				if (wave_mode_field == tmr_pkg::TMR_FAST) begin
					wave_next = compare_output_field[0];
				end
			end else if (bottom_event && wave_mode_field == tmr_pkg::TMR_FAST) begin
				wave_next = !compare_output_field[0];
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wave_reg <= 1'b0;
		end else begin
			wave_reg <= wave_next;
		end
	end

	assign waveform_output = wave_reg;
endmodule : tmr_wave

// ### hw/tmr_top.sv
// Top of the 8-bit single-compare PWM timer
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_top (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       external_count_pin,
	input  wire logic [2:0] clock_select_field,
	input  wire logic [1:0] wave_mode_field,
	input  wire logic [1:0] compare_output_field,
	input  wire logic       force_match_strobe,
	input  wire logic       count_wr,
	input  wire logic [7:0] count_wdata,
	input  wire logic       compare_wr,
	input  wire logic [7:0] compare_wdata,
	input  wire logic       flag_wr,
	input  wire logic [1:0] flag_wdata,
	input  wire logic       mask_wr,
	input  wire logic [1:0] mask_wdata,
	input  wire logic       global_irq_enable,
	input  wire logic       overflow_irq_ack,
	input  wire logic       match_irq_ack,
	output logic [7:0]      count_value,
	output logic [7:0]      compare_value,
	output logic [1:0]      timer_flag_register,
	output logic [1:0]      timer_mask_register,
	output logic            overflow_irq,
	output logic            match_irq,
	output logic            waveform_output
);
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic [7:0] compare_reg;
	logic [7:0] compare_buf_reg;
	logic       up_reg;
	logic       up_next;
	logic       ovf_reg;
	logic       match_flag_reg;
	logic [1:0] mask_reg;
	logic       block_reg;
	logic       timer_tick;
	logic       match;
	logic       match_event;
	logic       ovf_event;
	logic       top_hit;
	logic       double_buf;
	logic [7:0] top_value;
	tmr_pkg::tmr_mode_e mode;

	assign mode       = tmr_pkg::tmr_mode_e'(wave_mode_field);
	assign double_buf = wave_mode_field[0];
	assign match      = (count_reg == compare_reg);

	// ==========================================
	// Tick source
	tmr_tick_sel u_tick (
		.core_clk           (core_clk),
		.rst                (rst),
		.clock_select_field (clock_select_field),
		.external_count_pin (external_count_pin),
		.timer_tick         (timer_tick)
	);

	// ==========================================
	// Counting sequence
	always_comb begin
		top_value = (mode == tmr_pkg::TMR_CTC) ? compare_reg : `TMR_MAX;
		top_hit   = (count_reg == top_value);
	end

	always_comb begin
		count_next = count_reg;
		up_next    = up_reg;
		ovf_event  = 1'b0;
		if (timer_tick) begin
			case (mode)
				tmr_pkg::TMR_NORMAL: begin
					count_next = count_reg + 8'h01;
					ovf_event  = (count_reg == `TMR_MAX);
				end
				tmr_pkg::TMR_CTC: begin
					if (match) begin
						count_next = `TMR_BOTTOM;
					end else begin
						count_next = count_reg + 8'h01;
					end
					ovf_event = (count_reg == `TMR_MAX);
				end
				tmr_pkg::TMR_FAST: begin
					if (count_reg == `TMR_MAX) begin
						count_next = `TMR_BOTTOM;
					end else begin
						count_next = count_reg + 8'h01;
					end
					ovf_event = (count_reg == `TMR_MAX);
				end
				tmr_pkg::TMR_PHASE: begin
					if (up_reg && count_reg == `TMR_MAX) begin
						up_next    = 1'b0;
						count_next = count_reg - 8'h01;
					end else if (!up_reg && count_reg == `TMR_BOTTOM) begin
						up_next    = 1'b1;
						count_next = count_reg + 8'h01;
						ovf_event  = 1'b1;
					end else if (up_reg) begin
						count_next = count_reg + 8'h01;
					end else begin
						count_next = count_reg - 8'h01;
					end
				end
				default: count_next = count_reg;
			endcase
		end
		if (mode != tmr_pkg::TMR_PHASE) begin
			up_next = 1'b1;
		end
		if (count_wr) begin
			count_next = count_wdata;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_reg <= `TMR_RST_BYTE;
			up_reg    <= 1'b1;
		end else begin
			count_reg <= count_next;
			up_reg    <= up_next;
		end
	end

	// ==========================================
	// Match blocking after a count write
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			block_reg <= 1'b0;
		end else if (count_wr) begin
			block_reg <= 1'b1;
		end else if (timer_tick) begin
			block_reg <= 1'b0;
		end
	end

	// Match is acted on at the tick that follows equality
	assign match_event = timer_tick && match && !block_reg && !count_wr;

	// ==========================================
	// Compare value and its buffer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			compare_reg     <= `TMR_RST_BYTE;
			compare_buf_reg <= `TMR_RST_BYTE;
		end else begin
			if (compare_wr) begin
				compare_buf_reg <= compare_wdata;
			end
			if (!double_buf && compare_wr) begin
				compare_reg <= compare_wdata;
			end else if (double_buf && timer_tick) begin
				// Fast PWM loads at max, phase correct at max turnaround
				if (count_reg == `TMR_MAX) begin
					compare_reg <= compare_buf_reg;
				end
			end
		end
	end

	assign compare_value = double_buf ? compare_buf_reg : compare_reg;

	// ==========================================
	// Flags and masks
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ovf_reg        <= 1'b0;
			match_flag_reg <= 1'b0;
		end else begin
			if (ovf_event) begin
				ovf_reg <= 1'b1;
			end else if (overflow_irq_ack || (flag_wr && flag_wdata[0])) begin
				ovf_reg <= 1'b0;
			end
			if (match_event) begin
				match_flag_reg <= 1'b1;
			end else if (match_irq_ack || (flag_wr && flag_wdata[1])) begin
				match_flag_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mask_reg <= 2'h0;
		end else if (mask_wr) begin
			mask_reg <= mask_wdata;
		end
	end

	assign match_irq    = match_flag_reg && mask_reg[1] && global_irq_enable;
	assign overflow_irq = ovf_reg && mask_reg[0] && global_irq_enable;

	// ==========================================
	// Waveform generator
	tmr_wave u_wave (
		.core_clk             (core_clk),
		.rst                  (rst),
		.wave_mode_field      (wave_mode_field),
		.compare_output_field (compare_output_field),
		.match_event          (match_event),
		.force_event          (force_match_strobe),
		.bottom_event         (timer_tick && count_reg == `TMR_MAX),
		.up_dir               (up_reg),
		.waveform_output      (waveform_output)
	);

	assign count_value         = count_reg;
	assign timer_flag_register = {match_flag_reg, ovf_reg};
	assign timer_mask_register = mask_reg;
endmodule : tmr_top

// ### tb/tmr_pin_src.sv
// Count pin source standing in for the outside event line
`timescale 1ns/1ps
module tmr_pin_src (
	input  wire logic       core_clk,
	input  wire logic       start,
	input  wire logic [3:0] n,
	output logic            pin
);
	logic [4:0] left = 5'h00;
	logic [1:0] div  = 2'h0;
	initial pin = 1'b0;
	// Two toggles per pulse, four clocks apart; idles low
	always @(posedge core_clk) begin
		if (start) begin
			left <= {n, 1'b0};
			div  <= 2'h0;
		end else if (left != 5'h00) begin
			div <= div + 2'h1;
			if (div == 2'h3) begin
				pin  <= ~pin;
				left <= left - 5'h01;
			end
		end
	end
endmodule : tmr_pin_src

// ### tb/tmr_monitor.sv
// Port checker for the timer top
`timescale 1ns/1ps
module tmr_monitor (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [2:0] clock_select_field,
	input wire logic [1:0] wave_mode_field,
	input wire logic       count_wr,
	input wire logic [7:0] count_wdata,
	input wire logic       compare_wr,
	input wire logic [7:0] compare_wdata,
	input wire logic       mask_wr,
	input wire logic [1:0] mask_wdata,
	input wire logic       global_irq_enable,
	input wire logic [7:0] count_value,
	input wire logic [7:0] compare_value,
	input wire logic [1:0] timer_flag_register,
	input wire logic [1:0] timer_mask_register,
	input wire logic       overflow_irq,
	input wire logic       match_irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_norm_run;
		wave_mode_field == 2'h0 && !count_wr;
	endsequence
	sequence s_wrap;
		s_norm_run ##0 count_value == 8'hff ##1 count_value == 8'h00;
	endsequence
	a_match_irq_gate: assert property (match_irq == (timer_flag_register[1] &
		timer_mask_register[1] & global_irq_enable)) else $error("match irq gating");
	a_ovf_irq_gate: assert property (overflow_irq == (timer_flag_register[0] &
		timer_mask_register[0] & global_irq_enable)) else $error("overflow irq gating");
	a_stop_holds: assert property (clock_select_field == 3'h0 &&
		$past(clock_select_field) == 3'h0 && !count_wr |=> $stable(count_value))
		else $error("stopped count moved");
	a_count_write_wins: assert property (count_wr |=>
		count_value == $past(count_wdata)) else $error("count write lost");
	a_mask_write: assert property (mask_wr |=>
		timer_mask_register == $past(mask_wdata)) else $error("mask write lost");
	a_compare_access: assert property (compare_wr ##1 $stable(wave_mode_field) |->
		compare_value == $past(compare_wdata)) else $error("compare write lost");
	a_normal_step: assert property (s_norm_run |=> (count_value == $past(count_value) ||
		count_value == $past(count_value) + 8'h01)) else $error("normal count step");
	a_wrap_overflow: assert property (s_wrap |->
		timer_flag_register[0]) else $error("no overflow at wrap");
endmodule : tmr_monitor
bind tmr_top tmr_monitor i_mon (.core_clk, .rst, .clock_select_field, .wave_mode_field,
	.count_wr, .count_wdata, .compare_wr, .compare_wdata, .mask_wr, .mask_wdata,
	.global_irq_enable, .count_value, .compare_value, .timer_flag_register,
	.timer_mask_register, .overflow_irq, .match_irq);

// ### tb/tb.sv
// Self-checking testbench for the timer top
`timescale 1ns/1ps
module tb;
	logic       core_clk = 1'b0, rst = 1'b1, count_wr = 1'b0, compare_wr = 1'b0, go = 1'b0;
	logic       flag_wr = 1'b0, mask_wr = 1'b0, global_irq_enable = 1'b0;
	logic       force_match_strobe = 1'b0, overflow_irq_ack = 1'b0, match_irq_ack = 1'b0;
	logic [2:0] clock_select_field = 3'h0;
	logic [1:0] wave_mode_field = 2'h0, compare_output_field = 2'h0;
	logic [1:0] flag_wdata = 2'h0, mask_wdata = 2'h0, timer_flag_register, timer_mask_register;
	logic [7:0] count_wdata = 8'h00, compare_wdata = 8'h00, count_value, compare_value;
	logic       overflow_irq, match_irq, waveform_output, external_count_pin;
	logic [3:0] pulses = 4'h5;
	logic [1:0] com_tab [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
	logic [7:0] wave_tab [4] = '{8'h01, 8'h00, 8'h01, 8'h00};
	int         num_errors = 0;
	int         num_checks = 0;

	always #10 core_clk = ~core_clk;

	tmr_pin_src i_pin (.core_clk, .start(go), .n(pulses), .pin(external_count_pin));
	tmr_top i_dut (.core_clk, .rst, .external_count_pin, .clock_select_field, .wave_mode_field,
		.compare_output_field, .force_match_strobe, .count_wr, .count_wdata, .compare_wr,
		.compare_wdata, .flag_wr, .flag_wdata, .mask_wr, .mask_wdata, .global_irq_enable,
		.overflow_irq_ack, .match_irq_ack, .count_value, .compare_value, .timer_flag_register,
		.timer_mask_register, .overflow_irq, .match_irq, .waveform_output);

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(negedge core_clk);
	endtask : step
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
		step(1);
	endtask : pulse
	task automatic report_and_stop();
		if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop
	task automatic wait_cnt(input logic [7:0] v);
		int i;
		for (i = 0; i < 600 && count_value !== v; i++) step(1);
		if (i == 600) begin
			num_errors++;
			report_and_stop();
		end
	endtask : wait_cnt

	initial begin
		step(2);
		rst = 1'b0;
		chk(count_value, 8'h00);
		chk(compare_value, 8'h00);
		chk({4'h0, timer_flag_register, timer_mask_register}, 8'h00);
		chk({7'h0, waveform_output}, 8'h00);
		count_wdata = 8'hfd;
		pulse(count_wr);
		clock_select_field = 3'h1;
		wait_cnt(8'hff);
		step(1);
		chk(count_value, 8'h00);
		chk({7'h0, timer_flag_register[0]}, 8'h01);
		mask_wdata = 2'h1;
		global_irq_enable = 1'b1;
		pulse(mask_wr);
		chk({7'h0, overflow_irq}, 8'h01);
		pulse(overflow_irq_ack);
		chk({7'h0, timer_flag_register[0]}, 8'h00);
		flag_wdata = 2'h3;
		pulse(flag_wr);
		chk({6'h0, timer_flag_register}, 8'h00);
		clock_select_field = 3'h0;
		count_wdata = 8'h0c;
		pulse(count_wr);
		step(3);
		chk(count_value, 8'h0c);
		compare_wdata = 8'h10;
		pulse(compare_wr);
		chk(compare_value, 8'h10);
		clock_select_field = 3'h1;
		wait_cnt(8'h10);
		chk({7'h0, timer_flag_register[1]}, 8'h00);
		step(1);
		chk({7'h0, timer_flag_register[1]}, 8'h01);
		mask_wdata = 2'h2;
		pulse(mask_wr);
		chk({7'h0, match_irq}, 8'h01);
		global_irq_enable = 1'b0;
		step(1);
		chk({7'h0, match_irq}, 8'h00);
		pulse(match_irq_ack);
		chk({7'h0, timer_flag_register[1]}, 8'h00);
		clock_select_field = 3'h0;
		compare_wdata = 8'h30;
		pulse(compare_wr);
		count_wdata = 8'h30;
		pulse(count_wr);
		clock_select_field = 3'h1;
		step(3);
		chk({7'h0, timer_flag_register[1]}, 8'h00);
		chk(count_value, 8'h33);
		clock_select_field = 3'h0;
		for (int i = 0; i < 4; i++) begin
			compare_output_field = com_tab[i];
			pulse(force_match_strobe);
			chk({7'h0, waveform_output}, wave_tab[i]);
		end
		chk({6'h0, timer_flag_register}, 8'h00);
		compare_output_field = 2'h3;
		pulse(force_match_strobe);
		wave_mode_field = 2'h3;
		compare_output_field = 2'h2;
		pulse(force_match_strobe);
		chk({7'h0, waveform_output}, 8'h01);
		wave_mode_field = 2'h0;
		compare_output_field = 2'h0;
		pulse(force_match_strobe);
		chk({7'h0, waveform_output}, 8'h01);
		chk(count_value, 8'h33);
		wave_mode_field = 2'h2;
		compare_wdata = 8'h05;
		pulse(compare_wr);
		count_wdata = 8'h00;
		pulse(count_wr);
		clock_select_field = 3'h1;
		repeat (20) begin
			step(1);
			chk({7'h0, count_value > 8'h05}, 8'h00);
		end
		for (int m = 0; m < 2; m++) begin
			wave_mode_field = m ? 2'h3 : 2'h1;
			count_wdata = 8'hfe;
			pulse(count_wr);
			wait_cnt(8'hff);
			step(1);
			chk(count_value, m ? 8'h00 : 8'hfe);
		end
		// Fast PWM: new compare value waits in the buffer until the max tick
		compare_output_field = 2'h2;
		clock_select_field = 3'h0;
		compare_wdata = 8'h80;
		pulse(compare_wr);
		chk(compare_value, 8'h80);
		count_wdata = 8'h00;
		pulse(count_wr);
		clock_select_field = 3'h1;
		wait_cnt(8'h10);
		chk({7'h0, waveform_output}, 8'h00);
		wait_cnt(8'hff);
		step(1);
		chk({7'h0, waveform_output}, 8'h01);
		wait_cnt(8'h10);
		chk({7'h0, waveform_output}, 8'h01);
		wait_cnt(8'h81);
		chk({7'h0, waveform_output}, 8'h00);
		wave_mode_field = 2'h0;
		for (int e = 0; e < 2; e++) begin
			clock_select_field = e ? 3'h7 : 3'h6;
			count_wdata = 8'h00;
			pulse(count_wr);
			pulse(go);
			step(60);
			chk(count_value, 8'h05);
		end
		// Reset with the counter stopped, and count, compare and mask non-zero
		clock_select_field = 3'h0;
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		chk(count_value, 8'h00);
		chk(compare_value, 8'h00);
		chk({4'h0, timer_flag_register, timer_mask_register}, 8'h00);
		chk({7'h0, waveform_output}, 8'h00);
		report_and_stop();
	end
endmodule : tb
